// [cofd_map.svh]
// register offsets, field positions, reset values for the output stage
// assumes inclusion by bare name from design files
`ifndef COFD_MAP_SVH
`define COFD_MAP_SVH
`define COFD_ADDR_DIV01     8'h21
`define COFD_ADDR_CTL2      8'h22
`define COFD_ADDR_CTL3      8'h23
`define COFD_RST_DIV01      8'h01
`define COFD_RST_CTL2       8'hb0
`define COFD_RST_CTL3       8'h30
`define COFD_RSV_MSB        7
`define COFD_SEL_MSB        6
`define COFD_SEL_LSB        5
`define COFD_MODEA_MSB      4
`define COFD_MODEA_LSB      3
`define COFD_MODEB_MSB      2
`define COFD_MODEB_LSB      1
`endif

// [cofd_pkg.sv]
// types for the clock output divider and format block
// assumes no surroundings; holds types only
package cofd_pkg;
   typedef enum logic [1:0] {
      COFD_FMT_OFF,
      COFD_FMT_ACDIFF,
      COFD_FMT_HCSL,
      COFD_FMT_CMOS
   } cofd_fmt_t;
   typedef enum logic [1:0] {
      COFD_PIN_TRI,
      COFD_PIN_LOW,
      COFD_PIN_INV,
      COFD_PIN_TRUE
   } cofd_pin_t;
   typedef enum {
      COFD_DIV_LOW,
      COFD_DIV_HIGH
   } cofd_div_state_t;
endpackage

// [cofd_div_if.sv]
// carries the shared divider setting and its divided clock enable
// assumes the main module drives code (the ratio minus one) and consumes tick
`timescale 1ns/1ps
interface cofd_div_if;
   logic [7:0] code;
   logic       tick;
   logic       level;
   modport ctrl (output code, input tick, input level);
   modport divr (input code, output tick, output level);
endinterface

// [cofd_divider.sv]
// integer divider, ratio is code plus one
// assumes the code may change at any time; a new code is compared against the running count at once
`timescale 1ns/1ps
module cofd_divider
   import cofd_pkg::*;
(
   // clock and reset
   input  wire logic clk_in,
   input  wire logic rst_n_in,
   // divider link
   cofd_div_if.divr  div
);
   logic [7:0]      count;
   logic [7:0]      next_count;
   cofd_div_state_t state;
   cofd_div_state_t next_state;
   logic            next_tick;
   logic            tick_q;

   always_comb begin
      next_count = count;
      next_state = state;
      next_tick  = 1'b0;
      if (count >= div.code) begin
         next_count = 8'h00;
         next_tick  = 1'b1;
         case (state)
            COFD_DIV_LOW:  next_state = COFD_DIV_HIGH;
            COFD_DIV_HIGH: next_state = COFD_DIV_LOW;
            default:       next_state = COFD_DIV_LOW;
         endcase
      end else begin
         next_count = count + 8'h01;
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         count  <= 8'h00;
         state  <= COFD_DIV_LOW;
         tick_q <= 1'b0;
      end else begin
         count  <= next_count;
         state  <= next_state;
         tick_q <= next_tick;
      end
   end

   assign div.tick  = tick_q;
   assign div.level = (state == COFD_DIV_HIGH);
endmodule

// [cofd_top.sv]
// output stage registers: shared ch0/1 divider, ch2/ch3 format control
// assumes a one-cycle strobe register port, synchronous inputs
`timescale 1ns/1ps
`include "cofd_map.svh"
module cofd_top
   import cofd_pkg::*;
(
   // clock and reset
   input  wire logic       clk_in,
   input  wire logic       rst_n_in,
   // register port
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   // channel 0/1 divided clock
   output logic            ch01_tick_out,
   output logic            ch01_clk_out,
   // channel 2 driver settings
   output logic      [1:0] ch2_fmt_out,
   output logic      [1:0] ch2_itail_out,
   output logic      [1:0] ch2_rload_out,
   output logic      [1:0] ch2_pos_out,
   output logic      [1:0] ch2_neg_out,
   // channel 3 driver settings
   output logic      [1:0] ch3_fmt_out,
   output logic      [1:0] ch3_itail_out,
   output logic      [1:0] ch3_rload_out,
   output logic      [1:0] ch3_pos_out,
   output logic      [1:0] ch3_neg_out
);
   // ******************************************************
   // registers
   // ******************************************************
   logic [7:0] chan01_output_divider;
   logic [7:0] chan2_output_control;
   logic [7:0] chan3_output_control;
   logic [7:0] next_div;
   logic [7:0] next_ctl2;
   logic [7:0] next_ctl3;
   logic [7:0] next_rdata;
   logic [7:0] rdata;

   // unmapped writes fall through and leave every register alone
   always_comb begin
      next_div  = chan01_output_divider;
      next_ctl2 = chan2_output_control;
      next_ctl3 = chan3_output_control;
      if (wr_in) begin
         case (addr_in)
            `COFD_ADDR_DIV01: next_div = wdata_in;
            // top bit kept writable; software is expected to clear it
            `COFD_ADDR_CTL2:  next_ctl2 = {wdata_in[7:1], 1'b0};
            `COFD_ADDR_CTL3:  next_ctl3 = {1'b0, wdata_in[6:1], 1'b0};
            default:          next_div = chan01_output_divider;
         endcase
      end
   end

   // data is zero outside the read cycle, so idle reads look unmapped
   always_comb begin
      next_rdata = 8'h00;
      if (rd_in) begin
         case (addr_in)
            `COFD_ADDR_DIV01: next_rdata = chan01_output_divider;
            `COFD_ADDR_CTL2:  next_rdata = chan2_output_control;
            `COFD_ADDR_CTL3:  next_rdata = chan3_output_control;
            default:          next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         chan01_output_divider <= `COFD_RST_DIV01;
         chan2_output_control  <= `COFD_RST_CTL2;
         chan3_output_control  <= `COFD_RST_CTL3;
         rdata                 <= 8'h00;
      end else begin
         chan01_output_divider <= next_div;
         chan2_output_control  <= next_ctl2;
         chan3_output_control  <= next_ctl3;
         rdata                 <= next_rdata;
      end
   end

   assign rdata_out = rdata;

   // ******************************************************
   // shared channel 0/1 divider
   // ******************************************************
   cofd_div_if div01 ();
   assign div01.code = chan01_output_divider;

   cofd_divider u_div01 (
      .clk_in   (clk_in),
      .rst_n_in (rst_n_in),
      .div      (div01)
   );

   // one tick per code+1 cycles; the level toggles, so it spans two ratios
   assign ch01_tick_out = div01.tick;
   assign ch01_clk_out  = div01.level;

   // ******************************************************
   // channel 2/3 driver decode
   // ******************************************************
   // decode runs on the next register value and is registered, so the
   // driver settings move at the same edge as the register and reach
   // the pads straight from flip-flops, without decode glitches
   logic [7:0] next_ctl [2];
   logic [1:0] fmt      [2];
   logic [1:0] itail    [2];
   logic [1:0] rload    [2];
   logic [1:0] pos      [2];
   logic [1:0] neg      [2];

   assign next_ctl[0] = next_ctl2;
   assign next_ctl[1] = next_ctl3;

   // fields not meaningful for the chosen format are forced to the
   // parked code 0 so the analog side never sees a stale setting
   for (genvar c = 0; c < 2; c++) begin : g_chan
      // reset settings, decoded from the register's reset value
      localparam logic [7:0] reset_ctl  = (c == 0) ? `COFD_RST_CTL2 :
                                                     `COFD_RST_CTL3;
      localparam logic [1:0] reset_sel  =
         reset_ctl[`COFD_SEL_MSB:`COFD_SEL_LSB];
      localparam logic [1:0] reset_moda =
         reset_ctl[`COFD_MODEA_MSB:`COFD_MODEA_LSB];
      localparam logic [1:0] reset_modb =
         reset_ctl[`COFD_MODEB_MSB:`COFD_MODEB_LSB];
      localparam logic       reset_diff =
         (reset_sel == COFD_FMT_ACDIFF) || (reset_sel == COFD_FMT_HCSL);
      localparam logic       reset_hcsl = (reset_sel == COFD_FMT_HCSL);
      localparam logic       reset_cmos = (reset_sel == COFD_FMT_CMOS);
      localparam logic [1:0] reset_tail = reset_diff ? reset_moda : 2'h0;
      localparam logic [1:0] reset_load = reset_hcsl ? reset_modb : 2'h0;
      localparam logic [1:0] reset_pinp = reset_cmos ? reset_moda : 2'h0;
      localparam logic [1:0] reset_pinn = reset_cmos ? reset_modb : 2'h0;

      logic [7:0] ctl;
      logic [1:0] moda;
      logic [1:0] modb;
      logic [1:0] sel;
      logic [1:0] tail;
      logic [1:0] load;
      logic [1:0] pin_p;
      logic [1:0] pin_n;
      logic [1:0] next_sel;
      logic [1:0] next_tail;
      logic [1:0] next_load;
      logic [1:0] next_pin_p;
      logic [1:0] next_pin_n;

      always_comb begin
         ctl        = next_ctl[c];
         next_sel   = ctl[`COFD_SEL_MSB:`COFD_SEL_LSB];
         moda       = ctl[`COFD_MODEA_MSB:`COFD_MODEA_LSB];
         modb       = ctl[`COFD_MODEB_MSB:`COFD_MODEB_LSB];
         next_tail  = 2'h0;
         next_load  = 2'h0;
         next_pin_p = COFD_PIN_TRI;
         next_pin_n = COFD_PIN_TRI;
         case (next_sel)
            COFD_FMT_ACDIFF: begin
               next_tail = moda;
            end
            COFD_FMT_HCSL: begin
               next_tail = moda;
               next_load = modb;
            end
            COFD_FMT_CMOS: begin
               next_pin_p = moda;
               next_pin_n = modb;
            end
            default: begin
               next_tail = 2'h0; // output off: everything stays parked
            end
         endcase
      end

      always_ff @(posedge clk_in or negedge rst_n_in) begin
         if (!rst_n_in) begin
            sel   <= reset_sel;
            tail  <= reset_tail;
            load  <= reset_load;
            pin_p <= reset_pinp;
            pin_n <= reset_pinn;
         end else begin
            sel   <= next_sel;
            tail  <= next_tail;
            load  <= next_load;
            pin_p <= next_pin_p;
            pin_n <= next_pin_n;
         end
      end

      assign fmt[c]   = sel;
      assign itail[c] = tail;
      assign rload[c] = load;
      assign pos[c]   = pin_p;
      assign neg[c]   = pin_n;
   end

   assign ch2_fmt_out   = fmt[0];
   assign ch2_itail_out = itail[0];
   assign ch2_rload_out = rload[0];
   assign ch2_pos_out   = pos[0];
   assign ch2_neg_out   = neg[0];
   assign ch3_fmt_out   = fmt[1];
   assign ch3_itail_out = itail[1];
   assign ch3_rload_out = rload[1];
   assign ch3_pos_out   = pos[1];
   assign ch3_neg_out   = neg[1];
endmodule

// [cofd_top_checker.sv]
// checker for the output stage register block
// assumes a bind onto cofd_top, one clock domain
`timescale 1ns/1ps
module cofd_top_checker (
   input wire logic       clk_in,
   input wire logic       rst_n_in,
   input wire logic [7:0] addr_in,
   input wire logic [7:0] wdata_in,
   input wire logic       wr_in,
   input wire logic       rd_in,
   input wire logic [7:0] rdata_out,
   input wire logic       ch01_tick_out,
   input wire logic [1:0] ch2_fmt_out,
   input wire logic [1:0] ch2_itail_out,
   input wire logic [1:0] ch2_rload_out,
   input wire logic [1:0] ch3_fmt_out,
   input wire logic [1:0] ch3_pos_out,
   input wire logic [1:0] ch3_neg_out
);
   // ****************
   // properties
   // ****************
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   logic w2, w3;
   assign w2 = wr_in && addr_in == 8'h22;
   assign w3 = wr_in && addr_in == 8'h23;
   fmt_two_a: assert property (
      w2 |=> ch2_fmt_out == $past(wdata_in[6:5]))
      else $error("ch2 format not taken from write");
   fmt_three_a: assert property (
      w3 |=> ch3_fmt_out == $past(wdata_in[6:5]))
      else $error("ch3 format not taken from write");
   tail_cur_a: assert property (
      w2 && (wdata_in[6:5] inside {2'h1, 2'h2})
      |=> ch2_itail_out == $past(wdata_in[4:3]))
      else $error("ch2 tail current wrong");
   cmos_pins_a: assert property (
      w3 && wdata_in[6:5] == 2'h3
      |=> ch3_pos_out == $past(wdata_in[4:3])
      && ch3_neg_out == $past(wdata_in[2:1]))
      else $error("ch3 pin states wrong");
   hcsl_load_a: assert property (
      w2 && wdata_in[6:5] == 2'h2
      |=> ch2_rload_out == $past(wdata_in[2:1]))
      else $error("ch2 load wrong");
   unmapped_zero_a: assert property (
      rd_in && !(addr_in inside {8'h21, 8'h22, 8'h23})
      |=> rdata_out == 8'h00)
      else $error("unmapped read not zero");
   rsv_bits_a: assert property (
      rd_in && addr_in == 8'h23
      |=> !rdata_out[7] && !rdata_out[0])
      else $error("reserved bits not zero");
   tick_gap_a: assert property (
      ch01_tick_out |=> ##[0:256] ch01_tick_out)
      else $error("divider tick missing");
   cover property (w2 && wdata_in[6:5] == 2'h3);
   cover property (rd_in && addr_in == 8'h21);
   cover property (ch01_tick_out);
endmodule
bind cofd_top cofd_top_checker cofd_top_checker_inst (.clk_in, .rst_n_in,
   .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out, .ch01_tick_out,
   .ch2_fmt_out, .ch2_itail_out, .ch2_rload_out, .ch3_fmt_out,
   .ch3_pos_out, .ch3_neg_out);

// [clock_output_divider_and_format_tb.sv]
// testbench for the output stage register block
// assumes cofd_top with its checker bound in
`timescale 1ns/1ps
module clock_output_divider_and_format_tb;
   logic       clk_in = 0, rst_n_in = 0, wr_in = 0, rd_in = 0;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, rdata_out;
   logic       ch01_tick_out, ch01_clk_out, lvl;
   logic [1:0] f2, i2, l2, p2, n2, f3, i3, l3, p3, n3, f, a;
   int         err_count = 0, compares = 0, n;
   always #5 clk_in = ~clk_in;
   cofd_top cofd_top_inst (.clk_in, .rst_n_in, .addr_in, .wdata_in, .wr_in,
      .rd_in, .rdata_out, .ch01_tick_out, .ch01_clk_out, .ch2_fmt_out(f2),
      .ch2_itail_out(i2), .ch2_rload_out(l2), .ch2_pos_out(p2),
      .ch2_neg_out(n2), .ch3_fmt_out(f3), .ch3_itail_out(i3),
      .ch3_rload_out(l3), .ch3_pos_out(p3), .ch3_neg_out(n3));
   // ****************
   // tasks
   // ****************
   task chk(input logic [9:0] g, input logic [9:0] e);
      compares++;
      if (g !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h exp %h", $time, g, e);
      end
   endtask
   task wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk_in);
      addr_in  <= ad;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
   endtask
   task rd(input logic [7:0] ad, input logic [7:0] e);
      @(posedge clk_in);
      addr_in <= ad;
      rd_in   <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1 chk(rdata_out, e);
   endtask
   task stop_test;
      $display("errors %0d compares %0d", err_count, compares);
      if (err_count == 0 && compares > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   // tick is sampled 1 ns after the edge, where the register has settled
   task tick_gap;
      n = 0;
      do begin
         @(posedge clk_in);
         #1;
         n++;
      end while (ch01_tick_out !== 1'b1 && n < 600);
      if (ch01_tick_out !== 1'b1) begin
         err_count++;
         $display("unexpected at %0t: divider tick missing", $time);
         stop_test;
      end
   endtask
   // ****************
   // sequence
   // ****************
   initial begin
      repeat (20) @(posedge clk_in);
      rst_n_in <= 1'b1;
      #1 chk({f2, i2, l2, p2, n2}, 10'h180);
      chk({f3, i3, l3, p3, n3}, 10'h180);
      rd(8'h21, 8'h01);
      rd(8'h22, 8'hb0);
      rd(8'h23, 8'h30);
      wr(8'h20, 8'h55);
      rd(8'h20, 8'h00);
      rd(8'h21, 8'h01);
      wr(8'h23, 8'hff);
      rd(8'h23, 8'h7e);
      wr(8'h22, 8'hff);
      rd(8'h22, 8'hfe);
      // every format against each mode A value with mode B its inverse, both channels
      for (int c = 0; c < 32; c++) begin
         {f, a} = c[3:0];
         wr(8'h22 + c[4], {1'b0, f, a, ~a, 1'b0});
         chk(c[4] ? {f3, i3, l3, p3, n3} : {f2, i2, l2, p2, n2},
            {f, f inside {2'h1, 2'h2} ? a : 2'h0, f == 2'h2 ? ~a : 2'h0,
            f == 2'h3 ? a : 2'h0, f == 2'h3 ? ~a : 2'h0});
      end
      for (int c = 0; c < 3; c++) begin
         wr(8'h21, c == 0 ? 8'h00 : c == 1 ? 8'h03 : 8'hff);
         tick_gap;
         tick_gap;
         tick_gap;
         chk(n[9:0], c == 0 ? 10'h001 : c == 1 ? 10'h004 : 10'h100);
         lvl = ch01_clk_out;
         tick_gap;
         chk(ch01_clk_out, !lvl);
      end
      // a reset in mid-run brings every register back to its reset value
      @(posedge clk_in);
      rst_n_in <= 1'b0;
      repeat (2) @(posedge clk_in);
      rst_n_in <= 1'b1;
      #1 chk({f2, i2, l2, p2, n2}, 10'h180);
      chk({f3, i3, l3, p3, n3}, 10'h180);
      rd(8'h21, 8'h01);
      rd(8'h22, 8'hb0);
      rd(8'h23, 8'h30);
      stop_test;
   end
endmodule
